// ===== design/stm_params.svh
// Purpose: Offsets, counter limit and reset values of the standard timer
// Assumes: Byte-wide registers, each on its own 32-bit Wishbone word
// Notes: Definitions only
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH

`define STM_ADDR_W 4
`define STM_OFF_CTRL0 4'h0
`define STM_OFF_CTRL1 4'h4
`define STM_OFF_CNT_LOW 4'h8
`define STM_OFF_CNT_HIGH 4'hc
`define STM_OFF_CMPA_LOW 4'h0
`define STM_OFF_CMPA_HIGH 4'h4
`define STM_OFF_FLAGS 4'h8
`define STM_OFF_TICK 4'hc

`define STM_CTRL0_RESET 8'h00
`define STM_CTRL1_RESET 8'h00
`define STM_CNT_MAX 10'h3ff

`endif

// ===== design/stm_pkg.sv
// Purpose: Types shared by the standard timer
// Assumes: Nothing beyond the parameter header
// Notes: Holds types only
package stm_pkg;

  typedef enum logic [1:0] {
    STM_MODE_CMP = 2'h0,
    STM_MODE_CAP = 2'h1,
    STM_MODE_PWM = 2'h2,
    STM_MODE_TMR = 2'h3
  } stm_mode_t;

  typedef struct packed {
    stm_mode_t opmode;
    logic [1:0] out_func;
    logic out_init;
    logic out_inv;
    logic swap;
    logic clr_sel;
  } stm_ctrl1_t;

  typedef struct packed {
    logic run;
    logic [2:0] cmp_p;
  } stm_ctrl0_t;

  typedef struct packed {
    stm_ctrl0_t ctrl0;
    stm_ctrl1_t ctrl1;
    logic [9:0] cmp_a;
    logic [9:0] count;
    logic run_q;
    logic pin;
    logic flag_a;
    logic flag_p;
    logic ack;
    logic [7:0] rdata;
  } stm_state_t;

endpackage

// ===== design/stm_timer.sv
// Purpose: 10-bit standard timer with compare-match, timer and PWM modes
// Assumes: Timer clock enable tick_i is one cycle wide and synchronous to mclk_i
// Notes: Register map on classic Wishbone, one byte per 32-bit word, two pages
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "stm_params.svh"
`default_nettype none

module stm_timer
  import stm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic tick_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`STM_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_page_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic pin_o,
  output logic pin_oe_o,
  output logic flag_a_o,
  output logic flag_p_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  stm_state_t st;
  stm_state_t next_st;

  logic req;
  logic wr;
  logic [9:0] cnt;
  logic [9:0] cnt_inc;
  logic match_a;
  logic match_p;
  logic clear;
  logic raise_a;
  logic raise_p;
  logic is_pwm;
  logic [10:0] period;
  logic [10:0] duty;
  logic pwm_active;
  logic pwm_level;
  logic run_rise;
  logic [7:0] rd;

  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign cnt = st.count;
  assign cnt_inc = cnt + 10'h001;
  assign run_rise = st.ctrl0.run && !st.run_q;
  assign is_pwm = (st.ctrl1.opmode == STM_MODE_PWM);

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  always_comb begin
    // Matches fire on the tick that would carry the count onto the compare value,
    // so a clear there gives a period of exactly that many ticks
    // P value seen only against the top three counter bits; P of zero is the overflow
    match_p = (cnt_inc[9:7] == st.ctrl0.cmp_p) && (cnt_inc[6:0] == 7'h00);
    match_a = (cnt_inc == st.cmp_a) && (st.cmp_a != 10'h000);
    // Period and duty in timer ticks; P of zero means a full 1024
    if (!st.ctrl1.swap) begin
      period = (st.ctrl0.cmp_p == 3'h0) ? 11'h400 : {1'b0, st.ctrl0.cmp_p, 7'h00};
      duty = {1'b0, st.cmp_a};
    end else begin
      period = {1'b0, st.cmp_a};
      duty = (st.ctrl0.cmp_p == 3'h0) ? 11'h400 : {1'b0, st.ctrl0.cmp_p, 7'h00};
    end
    if (is_pwm) begin
      clear = st.ctrl1.swap ? match_a : match_p;
      raise_a = match_a;
      raise_p = match_p;
    end else if (st.ctrl1.clr_sel) begin
      clear = match_a;
      raise_a = match_a;
      raise_p = 1'b0;
    end else begin
      clear = match_p || (st.ctrl0.cmp_p == 3'h0 && cnt == `STM_CNT_MAX);
      raise_a = match_a;
      raise_p = match_p || (st.ctrl0.cmp_p == 3'h0 && cnt == `STM_CNT_MAX);
    end
    // Counter value c means c+1 ticks elapsed; active while below duty
    pwm_active = (duty >= period) || ({1'b0, cnt} < duty);
    pwm_level = pwm_active ? st.ctrl1.out_init : !st.ctrl1.out_init;
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd = 8'h00;
    if (!wb_page_i) begin
      if (wb_adr_i == `STM_OFF_CTRL0) begin
        rd = {4'h0, st.ctrl0.run, st.ctrl0.cmp_p};
      end else if (wb_adr_i == `STM_OFF_CTRL1) begin
        rd = st.ctrl1;
      end else if (wb_adr_i == `STM_OFF_CNT_LOW) begin
        rd = cnt[7:0];
      end else if (wb_adr_i == `STM_OFF_CNT_HIGH) begin
        rd = {6'h00, cnt[9:8]};
      end
    end else begin
      if (wb_adr_i == `STM_OFF_CMPA_LOW) begin
        rd = st.cmp_a[7:0];
      end else if (wb_adr_i == `STM_OFF_CMPA_HIGH) begin
        rd = {6'h00, st.cmp_a[9:8]};
      end else if (wb_adr_i == `STM_OFF_FLAGS) begin
        rd = {6'h00, st.flag_p, st.flag_a};
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.rdata = req ? rd : 8'h00;
    next_st.run_q = st.ctrl0.run;
    // Software writes
    if (wr && !wb_page_i) begin
      if (wb_adr_i == `STM_OFF_CTRL0) begin
        next_st.ctrl0 = stm_ctrl0_t'(wb_dat_i[3:0]);
      end else if (wb_adr_i == `STM_OFF_CTRL1) begin
        next_st.ctrl1 = stm_ctrl1_t'(wb_dat_i[7:0]);
      end
    end else if (wr && wb_page_i) begin
      if (wb_adr_i == `STM_OFF_CMPA_LOW) begin
        next_st.cmp_a[7:0] = wb_dat_i[7:0];
      end else if (wb_adr_i == `STM_OFF_CMPA_HIGH) begin
        next_st.cmp_a[9:8] = wb_dat_i[1:0];
      end else if (wb_adr_i == `STM_OFF_FLAGS) begin
        // Write one to clear; a set in the same cycle wins below
        next_st.flag_a = st.flag_a && !wb_dat_i[0];
        next_st.flag_p = st.flag_p && !wb_dat_i[1];
      end
    end
    // Counter
    if (run_rise) begin
      next_st.count = 10'h000;
      next_st.pin = st.ctrl1.out_init;
    end else if (st.ctrl0.run && tick_i) begin
      // PWM counting runs whatever the output function is
      next_st.count = clear ? 10'h000 : cnt + 10'h001;
      if (raise_a) begin
        next_st.flag_a = 1'b1;
      end
      if (raise_p) begin
        next_st.flag_p = 1'b1;
      end
      if (raise_a && !is_pwm) begin
        case (st.ctrl1.out_func)
          2'h1: next_st.pin = 1'b0;
          2'h2: next_st.pin = 1'b1;
          2'h3: next_st.pin = !st.pin;
          default: next_st.pin = st.pin;
        endcase
      end
    end
    // Run low leaves count frozen: no branch touches it
    if (is_pwm) begin
      case (st.ctrl1.out_func)
        2'h0: next_st.pin = !st.ctrl1.out_init;
        2'h1: next_st.pin = st.ctrl1.out_init;
        2'h2: next_st.pin = run_rise ? st.ctrl1.out_init : pwm_level;
        default: next_st.pin = run_rise ? st.ctrl1.out_init : st.pin;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = st.ack;
  assign wb_dat_o = {24'h000000, st.rdata};
  assign pin_o = st.pin ^ st.ctrl1.out_inv;
  // timer mode and capture mode release the pin
  assign pin_oe_o = (st.ctrl1.opmode == STM_MODE_CMP) || is_pwm;
  assign flag_a_o = st.flag_a;
  assign flag_p_o = st.flag_p;

endmodule

`default_nettype wire

// ===== testbench/stm_props.sv
// Purpose: Port checker for stm_timer
// Assumes: One clock domain, synchronous active-low reset
// Notes: Attached to every stm_timer by the bind below
`timescale 1ns/1ps
`default_nettype none
module stm_props (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic tick_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pin_o,
  input wire logic flag_a_o,
  input wire logic flag_p_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request without ack");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper data bits set");
  chk_pin_cause: assert property ($changed(pin_o) |->
    wb_ack_o || $past(wb_ack_o) || $past(tick_i) || $past(tick_i, 2))
    else $error("pin moved without cause");
  chk_flag_src: assert property ($rose(flag_a_o) || $rose(flag_p_o) |->
    $past(tick_i) || $past(tick_i, 2))
    else $error("flag without tick");
  chk_flag_clear: assert property ($fell(flag_a_o) || $fell(flag_p_o) |->
    wb_ack_o && wb_we_i) else $error("flag lost without write");
endmodule
bind stm_timer stm_props i_stm_props (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .tick_i(tick_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_o(pin_o), .flag_a_o(flag_a_o),
  .flag_p_o(flag_p_o));
`default_nettype wire

// ===== testbench/test_stm_timer.sv
// Purpose: Self-checking bench for stm_timer
// Assumes: Timer tick on every clock except in the tick-low frozen-count check, so one tick is 50 ns
// Notes: Rows are {page, offset, write byte, read byte}
`timescale 1ns/1ps
`default_nettype none
module test_stm_timer;
  import stm_pkg::*;
  logic mclk_i = 0, nrst_i = 0, tick_i = 1, cyc = 0, we = 0, pg = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rd, dat, k;
  logic ack, pin, oe, fa, fp;
  int errors = 0, checks_done = 0, n;
  logic [20:0] rows [6] = '{{1'b1, 4'h0, 8'ha5, 8'ha5}, {1'b1, 4'h4, 8'hff, 8'h03},
    {1'b0, 4'hc, 8'hff, 8'h00}, {1'b0, 4'h0, 8'h07, 8'h07},
    {1'b0, 4'h4, 8'h5a, 8'h5a}, {1'b1, 4'hc, 8'hff, 8'h00}};
  always #25 mclk_i = ~mclk_i;
  stm_timer i_stm_timer (.mclk_i(mclk_i), .nrst_i(nrst_i), .tick_i(tick_i),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wd), .wb_page_i(pg), .wb_dat_o(dat), .wb_ack_o(ack), .pin_o(pin),
    .pin_oe_o(oe), .flag_a_o(fa), .flag_p_o(fp));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Holds the request until ack is sampled high, then releases it
  task automatic bus(input logic w, input logic p, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge mclk_i);
    cyc <= 1'b1;
    we <= w;
    pg <= p;
    adr <= a;
    wd <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat;
    cyc <= 1'b0;
    if (n >= 20) chk(n, 0);
  endtask
  // Settles for one long frame, then counts pin highs over a window
  task automatic cnt(input int len, input logic [31:0] e);
    repeat (300) @(posedge mclk_i);
    k = 0;
    repeat (len) begin
      @(posedge mclk_i);
      k += pin;
    end
    chk(k, e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    errors++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    bus(0, 0, 4'h4, 8'h00);
    chk(rd, 0);
    foreach (rows[i]) begin
      bus(1, rows[i][20], rows[i][19:16], rows[i][15:8]);
      bus(0, rows[i][20], rows[i][19:16], 8'h00);
      chk(rd, rows[i][7:0]);
    end
    bus(1, 1, 4'h8, 8'h03);
    bus(1, 1, 4'h0, 8'h0a);
    bus(1, 1, 4'h4, 8'h00);
    bus(1, 0, 4'h4, 8'h39);
    bus(1, 0, 4'h0, 8'h09);
    repeat (3) @(posedge mclk_i);
    chk(pin, 1);
    for (n = 0; n < 100 && fa !== 1'b1; n++) @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    chk(pin, 0);
    bus(1, 1, 4'h4, 8'h01);
    repeat (300) @(posedge mclk_i);
    chk(fp, 0);
    bus(1, 0, 4'h0, 8'h00);
    bus(0, 0, 4'h8, 8'h00);
    k = rd;
    repeat (5) @(posedge mclk_i);
    bus(0, 0, 4'h8, 8'h00);
    chk(rd, k);
    bus(1, 1, 4'h8, 8'h03);
    bus(1, 1, 4'h4, 8'h00);
    bus(1, 0, 4'h4, 8'h38);
    bus(1, 0, 4'h0, 8'h09);
    repeat (300) @(posedge mclk_i);
    chk({fa, fp}, 2'h3);
    bus(1, 1, 4'h0, 8'h20);
    bus(1, 0, 4'h4, 8'ha8);
    cnt(128, 32);
    bus(1, 0, 4'h4, 8'hac);
    cnt(128, 96);
    bus(1, 1, 4'h0, 8'hc8);
    bus(1, 0, 4'h4, 8'ha8);
    cnt(128, 128);
    bus(1, 1, 4'h4, 8'h01);
    bus(1, 1, 4'h0, 8'h00);
    bus(1, 0, 4'h4, 8'haa);
    cnt(256, 128);
    bus(1, 0, 4'h4, 8'h8a);
    bus(1, 1, 4'h8, 8'h03);
    cnt(256, 0);
    chk({fa, fp}, 2'h3);
    bus(1, 0, 4'h4, 8'hc0);
    chk(oe, 0);
    bus(1, 0, 4'h4, 8'h00);
    chk(oe, 1);
    tick_i <= 1'b0;
    bus(0, 0, 4'h8, 8'h00);
    k = rd;
    repeat (20) @(posedge mclk_i);
    bus(0, 0, 4'h8, 8'h00);
    chk(rd, k);
    tick_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    bus(0, 0, 4'h8, 8'h00);
    chk(rd !== k, 1);
    nrst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk({fa, fp, pin, oe}, 4'h1);
    nrst_i <= 1'b1;
    bus(0, 0, 4'h4, 8'h00);
    chk(rd, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
